// File: verilog/msfs_pkg.sv
package msfs_pkg;

  // bank and page geometry of the digest bytes
  localparam int NUM_BANKS = 4;
  localparam int NUM_PAGES = 4;
  localparam int NUM_FLAG_PAGES = NUM_BANKS * NUM_PAGES;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_DIGEST0 = 8'h04;
  localparam logic [7:0] IDX_DIGEST3 = 8'h07;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h08;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h09;
  localparam logic [7:0] IDX_FLAG_BASE = 8'h10;
  localparam logic [7:0] IDX_FLAG_LAST = 8'h1F;

  // field positions of the status byte, and the digest field width
  localparam int STATE_LSB = 1;
  localparam int STATE_MSB = 3;
  localparam int IRQ_INACTIVE_BIT = 0;
  localparam int DIGEST_W = 4;

  // interrupt status and mask bit positions
  localparam int IRQ_W = 2;
  localparam int IRQB_STATE = 0;
  localparam int IRQB_FLAG = 1;

  // operating state codes
  typedef enum logic [2:0] {
    RESERVED0_STATE = 3'b000,
    LOW_POWER_STATE = 3'b001,
    POWERING_UP_STATE = 3'b010,
    OPERATIONAL_STATE = 3'b011,
    POWERING_DOWN_STATE = 3'b100,
    FAULT_STATE = 3'b101,
    RESERVED6_STATE = 3'b110,
    RESERVED7_STATE = 3'b111
  } msfs_state_t;

  // reset values, and the pages kept present whatever PAGE_SUPPORT says
  localparam msfs_state_t STATE_RST = LOW_POWER_STATE;
  localparam logic [1:0] IRQ_STAT_RST = 2'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [15:0] REQUIRED_PAGE_MASK = 16'h0001;

  // axi4-lite response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: verilog/msfs_flag_page.sv
module msfs_flag_page import msfs_pkg::*; #(
  parameter int FLAG_W = 8,
  parameter bit IMPL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [FLAG_W-1:0] set,
  input wire logic clr,
  output logic [FLAG_W-1:0] flags,
  output logic any,
  output logic new_evt
);

  logic [FLAG_W-1:0] set_eff;
  logic [FLAG_W-1:0] next_flags;

  // unimplemented pages never latch anything
  assign set_eff = IMPL ? set : '0;
  // read clears what was read; a set in the same cycle survives
  assign next_flags = clr ? set_eff : (flags | set_eff);
  assign new_evt = |(set_eff & ~flags);
  // live or, drops in the cycle the last flag clears
  assign any = |flags;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_clear_on_read: assert property (clr |=> flags == $past(set_eff))
    else $error("flag page not cleared by read");
  a_latch_holds: assert property (!clr && |set_eff |=> (flags & $past(set_eff)) == $past(set_eff))
    else $error("flag event not latched");

endmodule // msfs_flag_page

// File: verilog/msfs_top.sv
module msfs_top import msfs_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int FLAG_W = 8,
  parameter bit FLAT_MEM = 1'b0,
  parameter logic [15:0] PAGE_SUPPORT = 16'hFFFF
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [2:0] STATE_IN,
  input wire logic [NUM_FLAG_PAGES*FLAG_W-1:0] FLAG_EVT,
  output logic IRQ,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  localparam int NF = NUM_FLAG_PAGES;
  localparam int IDX_W = ADDR_W - 2;
  // a flat build must show ready even on the first edge out of reset
  localparam msfs_state_t STATE_INIT = FLAT_MEM ? OPERATIONAL_STATE : STATE_RST;

  // index of an address with the low two bits dropped; in_range treats misaligned ones as out of range
  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[ADDR_W-1:2];
  endfunction

  function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a[1:0] == 2'b00) && (word_idx(a) >= IDX_W'(lo)) && (word_idx(a) <= IDX_W'(hi));
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = in_range(a, IDX_STATUS, IDX_IRQ_MASK) || in_range(a, IDX_FLAG_BASE, IDX_FLAG_LAST);
  endfunction

  function automatic logic state_legal(input logic [2:0] s);
    state_legal = (s >= LOW_POWER_STATE) && (s <= FAULT_STATE);
  endfunction

  msfs_state_t state_q;
  msfs_state_t next_state;
  logic state_chg;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_w1c;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [FLAG_W-1:0] flag_q [NF];
  logic [NF-1:0] page_any;
  logic [NF-1:0] page_new;
  logic [NF-1:0] page_clr;
  logic [NF-1:0] page_impl;

  // state register: reserved codes never reach the host
  assign next_state = FLAT_MEM ? OPERATIONAL_STATE :
                      state_legal(STATE_IN) ? msfs_state_t'(STATE_IN) : state_q;
  assign state_chg = (next_state != state_q);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= STATE_INIT;
    end else begin
      state_q <= next_state;
    end
  end

  // flag pages, bank-major: page g is bank g/4, digest bit g%4
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : gen_page
      localparam bit IMPL = !FLAT_MEM && (PAGE_SUPPORT[g] || REQUIRED_PAGE_MASK[g]);
      assign page_impl[g] = IMPL;
      msfs_flag_page #(
        .FLAG_W(FLAG_W),
        .IMPL(IMPL)
      ) u_page (
        .clk(CLK),
        .rst(RST),
        .set(FLAG_EVT[g*FLAG_W +: FLAG_W]),
        .clr(page_clr[g]),
        .flags(flag_q[g]),
        .any(page_any[g]),
        .new_evt(page_new[g])
      );
    end
  endgenerate

  // write channel capture, address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_hs;
  logic w_hs;
  logic wr_fire;
  logic wr_stat;
  logic wr_mask;

  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY = !w_held;
  assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID && S_AXI_WREADY;
  // a pending response stalls the next write commit
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
  assign wr_stat = wr_fire && in_range(aw_addr_q, IDX_IRQ_STAT, IDX_IRQ_STAT) && wstrb_q[0];
  assign wr_mask = wr_fire && in_range(aw_addr_q, IDX_IRQ_MASK, IDX_IRQ_MASK) && wstrb_q[0];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (aw_hs) begin
      aw_held <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      w_held <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (w_hs) begin
      w_held <= 1'b1;
      wdata_q <= S_AXI_WDATA;
      wstrb_q <= S_AXI_WSTRB;
    end
  end

  // read-only registers accept writes silently; holes answer slverr
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  assign irq_evt[IRQB_STATE] = state_chg;
  assign irq_evt[IRQB_FLAG] = |page_new;
  assign irq_w1c = wr_stat ? wdata_q[IRQ_W-1:0] : '0;
  assign next_irq_stat = (irq_stat & ~irq_w1c) | irq_evt;
  assign next_irq_mask = wr_mask ? wdata_q[IRQ_W-1:0] : irq_mask;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_stat <= IRQ_STAT_RST;
      irq_mask <= IRQ_MASK_RST;
      IRQ <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      IRQ <= |(irq_stat & irq_mask);
    end
  end

  // read decode; only flag pages clear on read, digests never
  logic ar_hs;
  logic rd_is_flag;
  logic [IDX_W-1:0] rd_idx;
  logic [IDX_W-1:0] rd_flag_off;
  logic [IDX_W-1:0] rd_dig_off;
  logic [7:0] status_byte;
  logic [7:0] digest_byte;
  logic [31:0] rd_word;

  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_idx = word_idx(S_AXI_ARADDR);
  assign rd_is_flag = in_range(S_AXI_ARADDR, IDX_FLAG_BASE, IDX_FLAG_LAST);
  assign rd_flag_off = rd_idx - IDX_W'(IDX_FLAG_BASE);
  assign rd_dig_off = rd_idx - IDX_W'(IDX_DIGEST0);
  // interrupt pin mirrored inverted, reads 1 from reset
  assign status_byte = {4'h0, state_q, !IRQ};
  // reserved upper nibble reads zero
  assign digest_byte = {4'h0, page_any[rd_dig_off[1:0]*DIGEST_W +: DIGEST_W]};

  generate
    for (g = 0; g < NF; g++) begin : gen_clr
      assign page_clr[g] = ar_hs && rd_is_flag && (rd_flag_off[3:0] == 4'(g));
    end
  endgenerate

  assign rd_word = in_range(S_AXI_ARADDR, IDX_STATUS, IDX_STATUS) ? {24'h00_0000, status_byte} :
                   in_range(S_AXI_ARADDR, IDX_DIGEST0, IDX_DIGEST3) ? {24'h00_0000, digest_byte} :
                   in_range(S_AXI_ARADDR, IDX_IRQ_STAT, IDX_IRQ_STAT) ? 32'(irq_stat) :
                   in_range(S_AXI_ARADDR, IDX_IRQ_MASK, IDX_IRQ_MASK) ? 32'(irq_mask) :
                   rd_is_flag ? 32'(flag_q[rd_flag_off[3:0]]) :
                   32'h0000_0000;

  // read answer one cycle after the address is taken
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (ar_hs) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // checks
  logic [NF-1:0] exp_any;
  logic rd_status;
  logic rd_digest;

  generate
    for (g = 0; g < NF; g++) begin : gen_exp
      assign exp_any[g] = |flag_q[g];
    end
  endgenerate
  assign rd_status = ar_hs && in_range(S_AXI_ARADDR, IDX_STATUS, IDX_STATUS);
  assign rd_digest = ar_hs && in_range(S_AXI_ARADDR, IDX_DIGEST0, IDX_DIGEST3);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_state_legal: assert property (rd_status |=> state_legal(S_AXI_RDATA[STATE_MSB:STATE_LSB]))
    else $error("reserved operating state reported");
  a_state_field: assert property (rd_status |=> S_AXI_RDATA[STATE_MSB:STATE_LSB] == $past(state_q))
    else $error("state field does not match state register");
  a_flat_ready: assert property (FLAT_MEM |-> state_q == OPERATIONAL_STATE)
    else $error("flat build not reporting ready");
  a_irq_mirror: assert property (rd_status |=> S_AXI_RDATA[IRQ_INACTIVE_BIT] == !$past(IRQ))
    else $error("interrupt mirror bit wrong");
  a_digest_live: assert property (page_any == exp_any)
    else $error("digest not a live or of flags");
  a_digest_read: assert property (rd_digest |=> S_AXI_RDATA[31:DIGEST_W] == '0 && S_AXI_RDATA[DIGEST_W-1:0] ==
                                  $past(page_any[rd_dig_off[1:0]*DIGEST_W +: DIGEST_W]))
    else $error("digest byte read back wrong");
  a_unsupported_zero: assert property ((page_any & ~page_impl) == '0 && page_impl[0] == !FLAT_MEM)
    else $error("unadvertised page shows a flag");
  a_digest_no_clear: assert property (rd_digest && FLAG_EVT == '0 |=> page_any == $past(page_any))
    else $error("digest read changed flags");
  a_flat_no_pages: assert property (FLAT_MEM |-> page_any == '0 && page_impl == '0)
    else $error("flat build has flag pages");
  a_irq_sticky: assert property (state_chg |=> irq_stat[IRQB_STATE] && irq_mask[IRQB_STATE] |=> IRQ)
    else $error("state change did not raise interrupt");
  a_read_latency: assert property (ar_hs |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");

  // outside a flat build legal codes pass straight through; reserved ones leave the register alone
  a_state_follows: assert property (!FLAT_MEM && state_legal(STATE_IN) |=> state_q == $past(STATE_IN))
    else $error("legal state code not taken");
  a_state_holds: assert property (!state_legal(STATE_IN) |=> $stable(state_q))
    else $error("reserved state code changed the state");

  // reserved bits of the status byte stay zero
  a_status_upper: assert property (rd_status |=> S_AXI_RDATA[31:STATE_MSB+1] == '0)
    else $error("reserved status bits not zero");

  // pin follows the unmasked status one edge later, both ways
  a_irq_follows: assert property (|(irq_stat & irq_mask) |=> IRQ)
    else $error("interrupt pin not raised");
  a_irq_quiet: assert property ((irq_stat & irq_mask) == '0 |=> !IRQ)
    else $error("interrupt pin raised without cause");

  // a new event survives a clear that lands in the same cycle
  a_set_wins: assert property (irq_evt[IRQB_FLAG] |=> irq_stat[IRQB_FLAG])
    else $error("flag event lost to a clear");
  a_irq_w1c: assert property (wr_stat && wdata_q[IRQB_STATE] && !irq_evt[IRQB_STATE] |=> !irq_stat[IRQB_STATE])
    else $error("write one did not clear status");

  // mask write lands on the edge after the commit
  a_mask_lands: assert property (wr_mask |=> irq_mask == $past(wdata_q[IRQ_W-1:0]))
    else $error("mask write did not land");

  // a committed write answers at once and frees both channels
  a_write_answer: assert property (wr_fire |=> S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write answer late");

  // answers stand until taken, and drop once taken
  a_bresp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  a_bvalid_drops: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  a_rdata_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA) &&
                                   $stable(S_AXI_RRESP))
    else $error("read answer dropped early");
  a_rvalid_drops: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");

  // holes and misaligned reads answer an error with zero data
  a_hole_error: assert property (ar_hs && !is_mapped(S_AXI_ARADDR) |=>
                                 S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == '0)
    else $error("hole read not refused");

  c_status_read: cover property (rd_status ##1 S_AXI_RVALID && S_AXI_RREADY);
  c_flag_cleared: cover property (page_any[0] ##1 page_clr[0] ##1 !page_any[0]);
  c_irq_raised: cover property (!IRQ ##1 IRQ);
  c_mask_write: cover property (wr_mask);
  c_set_beats_clear: cover property (wr_stat && irq_evt[IRQB_FLAG]);

endmodule // msfs_top

// File: dv/msfs_host.sv
module msfs_host (
  input wire logic clk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle master at time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // handshakes judged between edges, where every line is settled
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r, output bit to);
    bit ta, tw, tb;
    to = 1;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && to; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) begin
        awvalid <= 1'b0;
        awaddr <= ~a; // released lines stop showing the address
      end
      if (tw) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (tb) begin
        bready <= 1'b0;
        to = 0;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r, output bit to);
    bit ta, tr;
    to = 1;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && to; n++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (tr) begin
        rready <= 1'b0;
        to = 0;
      end
    end
  endtask
endmodule // msfs_host

// File: dv/test_module_status_flag_summary.sv
module test_module_status_flag_summary import msfs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [2:0] code; logic [31:0] stat;} msfs_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] state_in = 3'h1;
  logic [127:0] flag_evt = '0;
  logic irq, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [31:0] flat_rdata;
  logic flat_irq;
  int num_errors = 0;
  int compares = 0;
  // reserved codes keep the last legal state
  msfs_row_t rows [8] = '{'{3'h2, 32'h0000_0005}, '{3'h3, 32'h0000_0007}, '{3'h4, 32'h0000_0009},
    '{3'h5, 32'h0000_000B}, '{3'h6, 32'h0000_000B}, '{3'h0, 32'h0000_000B}, '{3'h7, 32'h0000_000B},
    '{3'h1, 32'h0000_0003}};
  always #5 clk = ~clk;
  // page 15 left unadvertised, page 0 too: it must stay present anyway
  msfs_top #(.PAGE_SUPPORT(16'h7FFE)) uut (.CLK(clk), .RST(rst), .STATE_IN(state_in), .FLAG_EVT(flag_evt),
    .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  // flat build on the same bus; it answers in lockstep, its read word stands after each read
  msfs_top #(.FLAT_MEM(1'b1)) flat_uut (.CLK(clk), .RST(rst), .STATE_IN(state_in), .FLAG_EVT(flag_evt),
    .IRQ(flat_irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(),
    .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(), .S_AXI_RDATA(flat_rdata), .S_AXI_RRESP(),
    .S_AXI_RVALID(), .S_AXI_RREADY(rready));
  msfs_host host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task automatic give_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: interrupt %b, expected %b", $time, got, exp);
    end
  endtask
  // a hung handshake ends the run at once
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bit to;
    host.rd(a, d, r, to);
    if (to) begin
      num_errors++;
      give_verdict();
    end else begin
      chk_word(d, exp);
      chk_word({30'h0, r}, {30'h0, er});
    end
  endtask
  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit to;
    host.wr(a, d, r, to);
    if (to) begin
      num_errors++;
      give_verdict();
    end else begin
      chk_word({30'h0, r}, {30'h0, er});
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(12'h00C, 32'h0000_0003, RESP_OKAY);
    chk_word(flat_rdata, 32'h0000_0007);
    rd_chk(12'h010, 32'h0000_0000, RESP_OKAY);
    chk_word(flat_rdata, 32'h0000_0000);
    // every state code, reserved ones included
    foreach (rows[i]) begin
      @(posedge clk);
      state_in <= rows[i].code;
      repeat (2) @(posedge clk);
      rd_chk(12'h00C, rows[i].stat, RESP_OKAY);
      chk_word(flat_rdata, 32'h0000_0007);
    end
    // one flag on each page; pages 0 to 14: digest read twice, then the page read clears it
    for (int g = 0; g < 16; g++) begin
      logic [11:0] da;
      da = 12'h010 + 12'(4 * (g / 4));
      @(posedge clk);
      flag_evt[g * 8 + g % 8] <= 1'b1;
      @(posedge clk);
      flag_evt <= '0;
      rd_chk(da, (g == 15) ? 32'h0 : 32'(1 << (g % 4)), RESP_OKAY);
      chk_word(flat_rdata, 32'h0000_0000);
      if (g != 15) begin
        rd_chk(da, 32'(1 << (g % 4)), RESP_OKAY);
        rd_chk(12'h040 + 12'(4 * g), 32'(1 << (g % 8)), RESP_OKAY);
        chk_word(flat_rdata, 32'h0000_0000);
        rd_chk(da, 32'h0, RESP_OKAY);
      end
    end
    // both events are pending: unmask, then clear
    wr_chk(12'h024, 32'h0000_0003, RESP_OKAY);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_bit(irq, 1'b1);
    chk_bit(flat_irq, 1'b0);
    rd_chk(12'h00C, 32'h0000_0002, RESP_OKAY);
    chk_word(flat_rdata, 32'h0000_0007);
    wr_chk(12'h020, 32'h0000_0003, RESP_OKAY);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_bit(irq, 1'b0);
    rd_chk(12'h00C, 32'h0000_0003, RESP_OKAY);
    // read-only status ignores writes; holes answer with an error
    wr_chk(12'h00C, 32'h0000_000E, RESP_OKAY);
    rd_chk(12'h00C, 32'h0000_0003, RESP_OKAY);
    rd_chk(12'h028, 32'h0000_0000, RESP_SLVERR);
    rd_chk(12'h00D, 32'h0000_0000, RESP_SLVERR);
    // reset in mid-run with a flag just latched
    @(posedge clk);
    flag_evt[0] <= 1'b1;
    @(posedge clk);
    flag_evt <= '0;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(12'h00C, 32'h0000_0003, RESP_OKAY);
    rd_chk(12'h010, 32'h0000_0000, RESP_OKAY);
    give_verdict();
  end
endmodule // test_module_status_flag_summary
